// ### logic/touch_tuning_pkg.sv
// constants, types and state layout of the touch tuning register bank
// Contract
// R1 - sensor turns active after difference beats threshold plus margin for debounce samples
// R2 - debounce accepts 1 to 255; one means the first qualifying sample activates
// R3 - raw count far below baseline leaves the baseline untouched that sample
// R4 - enough consecutive far-low samples load the baseline with the raw count
// R5 - debounce, negative noise and low baseline count are shared by all sensors
// R6 - writing one to filter bit 7 reloads all baselines, then bit self-clears
// R7 - drop bit 5 discards samples taken while serial traffic was active
// R8 - filter bit 4 enables averaging of raw counts, clear means none
// R9 - order field 1:0 picks averaging depth 2, 4, 8 or 16 samples
// R10 - sensors scanned in turn by their one-bit scan positions, defaults 0 and 1
// R11 - scan position registers take writes only in setup mode
// R12 - each sensor has its own eight-bit touch threshold, default 0x64
// R13 - writing zero to a current setting stores the default ten instead
// R14 - host should program current settings above four to limit noise
// R15 - host programs tuning registers after 0x07, 0x50 and 0x51
// R16 - bytes 3C, A5, 69 to the lock register unlock the address register
// R17 - bytes 96, 5A, C3 to the lock register lock the address register
// R18 - writes to the address register are ignored while locked
// R19 - a new address is used for matching only after locking again
// R20 - lock register bit 0 reads lock state, zero after reset
// R21 - second sensor threshold and current registers exist only on two-input variant
// R22 - active sensor turns inactive when difference drops below threshold minus margin
// R23 - debounce counter restarts when a sample fails to qualify
// R24 - low baseline counter restarts when a sample is not far low
// R25 - a stray byte abandons a lock sequence and keeps the lock state
package touch_tuning_pkg;

	// ==========================================
	// register offsets
	localparam logic [7:0] OFF_DEBOUNCE  = 8'h53;
	localparam logic [7:0] OFF_NEG_NOISE = 8'h54;
	localparam logic [7:0] OFF_LOW_BL    = 8'h55;
	localparam logic [7:0] OFF_FILTER    = 8'h56;
	localparam logic [7:0] OFF_SCAN0     = 8'h5C;
	localparam logic [7:0] OFF_SCAN1     = 8'h5D;
	localparam logic [7:0] OFF_THRESH0   = 8'h66;
	localparam logic [7:0] OFF_THRESH1   = 8'h67;
	localparam logic [7:0] OFF_CURRENT0  = 8'h70;
	localparam logic [7:0] OFF_CURRENT1  = 8'h71;
	localparam logic [7:0] OFF_LOCK      = 8'h79;
	localparam logic [7:0] OFF_BUS_ADDR  = 8'h7C;

	// ==========================================
	// field positions and masks
	localparam int         FLT_RESET_BIT = 7;
	localparam int         FLT_DROP_BIT  = 5;
	localparam int         FLT_AVG_BIT   = 4;
	localparam logic [7:0] FLT_WR_MASK   = 8'hB3;

	// ==========================================
	// reset values
	localparam logic [7:0] RST_DEBOUNCE  = 8'h0A;
	localparam logic [7:0] RST_NEG_NOISE = 8'h0A;
	localparam logic [7:0] RST_LOW_BL    = 8'h0A;
	localparam logic [7:0] RST_FILTER    = 8'h20;
	localparam logic       RST_SCAN0     = 1'h0;
	localparam logic       RST_SCAN1     = 1'h1;
	localparam logic [7:0] RST_THRESH    = 8'h64;
	localparam logic [7:0] RST_CURRENT   = 8'h0A;
	localparam logic [6:0] RST_BUS_ADDR  = 7'h2A; // arbitrary value

	// ==========================================
	// lock sequence bytes
	localparam logic [7:0] UNLOCK_B0 = 8'h3C;
	localparam logic [7:0] UNLOCK_B1 = 8'hA5;
	localparam logic [7:0] UNLOCK_B2 = 8'h69;
	localparam logic [7:0] LOCK_B0   = 8'h96;
	localparam logic [7:0] LOCK_B1   = 8'h5A;
	localparam logic [7:0] LOCK_B2   = 8'hC3;

	// ==========================================
	// types
	typedef enum logic [2:0] {SEQ_IDLE, SEQ_UN1, SEQ_UN2, SEQ_LK1, SEQ_LK2} lock_seq_t;

	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} reg_req_t;

	typedef struct packed {
		logic        valid;
		logic [15:0] count;
	} sample_t;

	typedef struct packed {
		logic [7:0]        debounce;
		logic [7:0]        neg_noise;
		logic [7:0]        low_bl;
		logic [7:0]        filter;
		logic [1:0]        scan_pos;
		logic [1:0][7:0]   thresh;
		logic [1:0][7:0]   current;
		logic              locked;
		lock_seq_t         seq;
		logic [6:0]        addr_pend;
		logic [6:0]        addr_used;
		logic [7:0]        rdata;
		logic              slot;
		logic              scan_ch;
		logic              busy_seen;
		logic [1:0]        reload;
		logic [1:0][15:0]  avg;
		logic [1:0][15:0]  base;
		logic [1:0][7:0]   db_cnt;
		logic [1:0][7:0]   low_cnt;
		logic [1:0]        active;
	} state_t;

endpackage

// ### logic/touch_tuning_regs.sv
// tuning register bank with baseline, debounce, scan order and address lock
`timescale 1ns/1ps
module touch_tuning_regs #(
	parameter bit TWO_INPUT = 1'b1
) (
	input  wire logic                       CLK,
	input  wire logic                       RESET_N,
	input  wire touch_tuning_pkg::reg_req_t REG,
	input  wire logic                       SETUP_MODE,
	input  wire logic                       BUS_ACTIVE,
	input  wire logic [7:0]                 THRESHOLD_MARGIN,
	input  wire touch_tuning_pkg::sample_t  SAMPLE,
	output logic [7:0]                      REG_RDATA,
	output logic                            SCAN_CH,
	output logic [1:0]                      SENSOR_ACTIVE,
	output logic [15:0]                     BASELINE0,
	output logic [15:0]                     BASELINE1,
	output logic [7:0]                      SENSE_CURRENT0,
	output logic [7:0]                      SENSE_CURRENT1,
	output logic [6:0]                      BUS_ADDR,
	output logic                            ADDRESS_LOCK_STATE
);

	// ==========================================
	// state
	touch_tuning_pkg::state_t q;
	touch_tuning_pkg::state_t d;

	// per-sample working values
	logic               ch;
	logic [15:0]        raw;
	logic signed [17:0] delta;
	logic signed [17:0] diff;
	logic signed [17:0] on_level;
	logic signed [17:0] off_level;
	logic signed [17:0] low_level;
	logic [7:0]         db_need;
	logic               next_slot;
	logic               drop;
	logic [2:0]         shift;

	// first byte of a lock or unlock sequence, anything else idles
	function automatic touch_tuning_pkg::lock_seq_t seq_start(input logic [7:0] b);
		touch_tuning_pkg::lock_seq_t s;
		s = touch_tuning_pkg::SEQ_IDLE;
		if (b == touch_tuning_pkg::UNLOCK_B0) begin
			s = touch_tuning_pkg::SEQ_UN1;
		end else if (b == touch_tuning_pkg::LOCK_B0) begin
			s = touch_tuning_pkg::SEQ_LK1;
		end
		return s;
	endfunction

	// ==========================================
	// next state
	always_comb begin
		d         = q;
		ch        = q.scan_ch;
		raw       = 16'h0000;
		delta     = 18'sh00000;
		diff      = 18'sh00000;
		on_level  = 18'sh00000;
		off_level = 18'sh00000;
		low_level = 18'sh00000;
		db_need   = 8'h01;
		next_slot = ~q.slot;
		drop      = 1'b0;
		shift     = {1'b0, q.filter[1:0]} + 3'h1;

		// R6 forced reload
		if (q.filter[touch_tuning_pkg::FLT_RESET_BIT]) begin
			d.filter[touch_tuning_pkg::FLT_RESET_BIT] = 1'b0;
			d.reload                                  = 2'b11;
		end

		// register writes
		if (REG.wr) begin
			unique case (REG.addr)
				touch_tuning_pkg::OFF_DEBOUNCE: begin
					// R5 shared setting
					d.debounce = REG.wdata;
				end
				touch_tuning_pkg::OFF_NEG_NOISE: begin
					d.neg_noise = REG.wdata;
				end
				touch_tuning_pkg::OFF_LOW_BL: begin
					d.low_bl = REG.wdata;
				end
				touch_tuning_pkg::OFF_FILTER: begin
					d.filter = REG.wdata & touch_tuning_pkg::FLT_WR_MASK;
				end
				touch_tuning_pkg::OFF_SCAN0: begin
					// R11 setup mode only
					if (SETUP_MODE) begin
						d.scan_pos[0] = REG.wdata[0];
					end
				end
				touch_tuning_pkg::OFF_SCAN1: begin
					if (SETUP_MODE && TWO_INPUT) begin
						d.scan_pos[1] = REG.wdata[0];
					end
				end
				touch_tuning_pkg::OFF_THRESH0: begin
					// R12 own threshold per sensor
					d.thresh[0] = REG.wdata;
				end
				touch_tuning_pkg::OFF_THRESH1: begin
					// R21 absent on single variant
					if (TWO_INPUT) begin
						d.thresh[1] = REG.wdata;
					end
				end
				touch_tuning_pkg::OFF_CURRENT0: begin
					// R13 zero restores default
					d.current[0] = (REG.wdata == 8'h00) ? touch_tuning_pkg::RST_CURRENT
						: REG.wdata;
				end
				touch_tuning_pkg::OFF_CURRENT1: begin
					if (TWO_INPUT) begin
						d.current[1] = (REG.wdata == 8'h00) ? touch_tuning_pkg::RST_CURRENT
							: REG.wdata;
					end
				end
				touch_tuning_pkg::OFF_LOCK: begin
					// R25 stray byte restarts the match
					d.seq = seq_start(REG.wdata);
					unique case (q.seq)
						touch_tuning_pkg::SEQ_UN1: begin
							if (REG.wdata == touch_tuning_pkg::UNLOCK_B1) begin
								d.seq = touch_tuning_pkg::SEQ_UN2;
							end
						end
						touch_tuning_pkg::SEQ_UN2: begin
							// R16 unlock completes
							if (REG.wdata == touch_tuning_pkg::UNLOCK_B2) begin
								d.seq    = touch_tuning_pkg::SEQ_IDLE;
								d.locked = 1'b0;
							end
						end
						touch_tuning_pkg::SEQ_LK1: begin
							if (REG.wdata == touch_tuning_pkg::LOCK_B1) begin
								d.seq = touch_tuning_pkg::SEQ_LK2;
							end
						end
						touch_tuning_pkg::SEQ_LK2: begin
							// R17 lock completes
							// R19 new address takes effect
							if (REG.wdata == touch_tuning_pkg::LOCK_B2) begin
								d.seq       = touch_tuning_pkg::SEQ_IDLE;
								d.locked    = 1'b1;
								d.addr_used = q.addr_pend;
							end
						end
						touch_tuning_pkg::SEQ_IDLE: begin
						end
					endcase
				end
				touch_tuning_pkg::OFF_BUS_ADDR: begin
					// R18 ignored while locked
					if (!q.locked) begin
						d.addr_pend = REG.wdata[6:0];
					end
				end
				default: begin
				end
			endcase
		end

		// register reads, unmapped reads zero
		if (REG.rd) begin
			unique case (REG.addr)
				touch_tuning_pkg::OFF_DEBOUNCE:  d.rdata = q.debounce;
				touch_tuning_pkg::OFF_NEG_NOISE: d.rdata = q.neg_noise;
				touch_tuning_pkg::OFF_LOW_BL:    d.rdata = q.low_bl;
				touch_tuning_pkg::OFF_FILTER:    d.rdata = q.filter;
				touch_tuning_pkg::OFF_SCAN0:     d.rdata = {7'h00, q.scan_pos[0]};
				touch_tuning_pkg::OFF_SCAN1:     d.rdata = TWO_INPUT ? {7'h00, q.scan_pos[1]}
					: 8'h00;
				touch_tuning_pkg::OFF_THRESH0:   d.rdata = q.thresh[0];
				touch_tuning_pkg::OFF_THRESH1:   d.rdata = TWO_INPUT ? q.thresh[1] : 8'h00;
				touch_tuning_pkg::OFF_CURRENT0:  d.rdata = q.current[0];
				touch_tuning_pkg::OFF_CURRENT1:  d.rdata = TWO_INPUT ? q.current[1] : 8'h00;
				// R20 lock state on bit 0
				touch_tuning_pkg::OFF_LOCK:      d.rdata = {7'h00, q.locked};
				touch_tuning_pkg::OFF_BUS_ADDR:  d.rdata = {1'b0, q.addr_pend};
				default:                         d.rdata = 8'h00;
			endcase
		end

		// serial traffic seen since the last sample
		d.busy_seen = q.busy_seen | BUS_ACTIVE;

		// ==========================================
		// sample processing for the scanned sensor
		if (SAMPLE.valid) begin
			d.busy_seen = BUS_ACTIVE;
			// R10 advance to the sensor holding the next position
			if (TWO_INPUT) begin
				d.slot    = next_slot;
				d.scan_ch = (q.scan_pos[0] != next_slot) && (q.scan_pos[1] == next_slot);
			end
			// R7 drop sample on bus traffic
			drop = q.filter[touch_tuning_pkg::FLT_DROP_BIT] && (q.busy_seen || BUS_ACTIVE);
			if (!drop) begin
				// R8 averaging enable
				// R9 depth from order field
				delta = $signed({2'b00, SAMPLE.count}) - $signed({2'b00, q.avg[ch]});
				if (q.filter[touch_tuning_pkg::FLT_AVG_BIT] && !q.reload[ch]) begin
					d.avg[ch] = 16'(q.avg[ch] + 16'(delta >>> shift));
				end else begin
					d.avg[ch] = SAMPLE.count;
				end
				raw = q.filter[touch_tuning_pkg::FLT_AVG_BIT] ? d.avg[ch] : SAMPLE.count;

				diff      = $signed({2'b00, raw}) - $signed({2'b00, q.base[ch]});
				on_level  = $signed({10'h000, q.thresh[ch]})
					+ $signed({10'h000, THRESHOLD_MARGIN});
				off_level = $signed({10'h000, q.thresh[ch]})
					- $signed({10'h000, THRESHOLD_MARGIN});
				low_level = -$signed({10'h000, q.neg_noise});
				// R2 setting of zero acts as one
				db_need   = (q.debounce == 8'h00) ? 8'h01 : q.debounce;

				if (q.reload[ch]) begin
					d.base[ch]    = raw;
					d.reload[ch]  = q.filter[touch_tuning_pkg::FLT_RESET_BIT]; // new reload wins
					d.low_cnt[ch] = 8'h00;
					d.db_cnt[ch]  = 8'h00;
					d.active[ch]  = 1'b0;
				end else begin
					// baseline tracking
					if (diff < low_level) begin
						// R3 hold baseline
						// R4 reload after enough low samples
						if (8'(q.low_cnt[ch] + 8'h01) >= q.low_bl) begin
							d.base[ch]    = raw;
							d.low_cnt[ch] = 8'h00;
						end else begin
							d.low_cnt[ch] = 8'(q.low_cnt[ch] + 8'h01);
						end
					end else begin
						// R24 restart low count
						d.low_cnt[ch] = 8'h00;
						if (diff < 0) begin
							d.base[ch] = raw;
						end else if (diff > 0 && !q.active[ch]) begin
							d.base[ch] = 16'(q.base[ch] + 16'h0001);
						end
					end
					// activation and release
					if (q.active[ch]) begin
						// R22 release below threshold minus margin
						if (diff < off_level) begin
							d.active[ch] = 1'b0;
						end
						d.db_cnt[ch] = 8'h00;
					end else if (diff > on_level) begin
						// R1 consecutive qualifying samples
						if (8'(q.db_cnt[ch] + 8'h01) >= db_need) begin
							d.active[ch] = 1'b1;
							d.db_cnt[ch] = 8'h00;
						end else begin
							d.db_cnt[ch] = 8'(q.db_cnt[ch] + 8'h01);
						end
					end else begin
						// R23 restart debounce
						d.db_cnt[ch] = 8'h00;
					end
				end
			end
		end
		if (!TWO_INPUT) begin
			d.active[1] = 1'b0;
		end
	end

	// ==========================================
	// state register, synchronous reset
	always_ff @(posedge CLK) begin
		if (!RESET_N) begin
			q           <= '0;
			q.debounce  <= touch_tuning_pkg::RST_DEBOUNCE;
			q.neg_noise <= touch_tuning_pkg::RST_NEG_NOISE;
			q.low_bl    <= touch_tuning_pkg::RST_LOW_BL;
			q.filter    <= touch_tuning_pkg::RST_FILTER;
			q.scan_pos  <= {touch_tuning_pkg::RST_SCAN1, touch_tuning_pkg::RST_SCAN0};
			q.thresh    <= {2{touch_tuning_pkg::RST_THRESH}};
			q.current   <= {2{touch_tuning_pkg::RST_CURRENT}};
			q.seq       <= touch_tuning_pkg::SEQ_IDLE;
			q.addr_pend <= touch_tuning_pkg::RST_BUS_ADDR;
			q.addr_used <= touch_tuning_pkg::RST_BUS_ADDR;
			q.reload    <= 2'b11;
		end else begin
			q <= d;
		end
	end

	// ==========================================
	// outputs straight from the state flops
	assign REG_RDATA          = q.rdata;
	assign SCAN_CH            = q.scan_ch;
	assign SENSOR_ACTIVE      = q.active;
	assign BASELINE0          = q.base[0];
	assign BASELINE1          = q.base[1];
	assign SENSE_CURRENT0     = q.current[0];
	assign SENSE_CURRENT1     = q.current[1];
	assign BUS_ADDR           = q.addr_used;
	assign ADDRESS_LOCK_STATE = q.locked;

endmodule

// ### verification/touch_host_model.sv
// host side model issuing register requests
`timescale 1ns/1ps
module touch_host_model (
	input wire logic                  clk,
	output touch_tuning_pkg::reg_req_t req,
	input wire logic [7:0]            rdata
);
	// idle bus at time zero
	initial req = '0;
	// one write, held to its edge, then scrambled
	task wr(input logic [7:0] a, input logic [7:0] d);
		req.addr = a;
		req.wdata = d;
		req.wr = 1'b1;
		@(posedge clk);
		#2;
		req.wr = 1'b0;
		req.addr = ~a;
		req.wdata = ~d;
		@(posedge clk);
		#2;
	endtask
	// one read, data taken after its edge
	task rd(input logic [7:0] a, output logic [7:0] d);
		req.addr = a;
		req.rd = 1'b1;
		@(posedge clk);
		#2;
		req.rd = 1'b0;
		req.addr = ~a;
		d = rdata;
		@(posedge clk);
		#2;
	endtask
	// three bytes to the lock register
	task seq3(input logic [7:0] b0, input logic [7:0] b1, input logic [7:0] b2);
		wr(8'h79, b0);
		wr(8'h79, b1);
		wr(8'h79, b2);
	endtask
	task prepare();
		wr(8'h07, 8'h00);
		wr(8'h50, 8'hA0);
		wr(8'h51, 8'h00);
	endtask
endmodule

// ### verification/touch_tuning_chk.sv
// port checker for the tuning register bank
`timescale 1ns/1ps
module touch_tuning_chk (
	input wire logic                       CLK,
	input wire logic                       RESET_N,
	input wire touch_tuning_pkg::reg_req_t REG,
	input wire touch_tuning_pkg::sample_t  SAMPLE,
	input wire logic [7:0]                 REG_RDATA,
	input wire logic [1:0]                 SENSOR_ACTIVE,
	input wire logic [15:0]                BASELINE0,
	input wire logic [7:0]                 SENSE_CURRENT0,
	input wire logic [7:0]                 SENSE_CURRENT1,
	input wire logic [6:0]                 BUS_ADDR,
	input wire logic                       ADDRESS_LOCK_STATE
);
	// ==========
	// helpers
	logic smp_q;
	logic lk_q;
	logic lk_end_q;
	logic lk_wr;
	assign lk_wr = REG.wr && REG.addr == touch_tuning_pkg::OFF_LOCK;
	// last cycle sample and closing lock bytes
	always_ff @(posedge CLK) begin
		smp_q    <= SAMPLE.valid;
		lk_q     <= lk_wr && (REG.wdata == 8'h69 || REG.wdata == 8'hC3);
		lk_end_q <= lk_wr && REG.wdata == 8'hC3;
	end
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (!RESET_N);
	// ==========
	// assertions
	chk_cur0_default: assert property (
		REG.wr && REG.addr == 8'h70 |=> SENSE_CURRENT0 ==
		($past(REG.wdata) == 8'h00 ? 8'h0A : $past(REG.wdata))) else $error("current 0 wrong");
	chk_cur1_default: assert property (
		REG.wr && REG.addr == 8'h71 |=> SENSE_CURRENT1 ==
		($past(REG.wdata) == 8'h00 ? 8'h0A : $past(REG.wdata))) else $error("current 1 wrong");
	chk_addr_hold: assert property (
		$past(RESET_N) && $changed(BUS_ADDR) |-> lk_end_q) else $error("address moved early");
	chk_lock_read: assert property (
		REG.rd && REG.addr == 8'h79 |=> REG_RDATA == {7'h00, $past(ADDRESS_LOCK_STATE)})
		else $error("lock read wrong");
	chk_unlock_seq: assert property (
		lk_wr && REG.wdata == 8'h3C ##2 lk_wr && REG.wdata == 8'hA5 ##2 lk_wr && REG.wdata == 8'h69
		|=> !ADDRESS_LOCK_STATE) else $error("unlock failed");
	chk_lock_seq: assert property (
		lk_wr && REG.wdata == 8'h96 ##2 lk_wr && REG.wdata == 8'h5A ##2 lk_wr && REG.wdata == 8'hC3
		|=> ADDRESS_LOCK_STATE) else $error("lock failed");
	chk_lock_stray: assert property (
		$past(RESET_N) && $changed(ADDRESS_LOCK_STATE) |-> lk_q) else $error("lock moved");
	chk_filter_clear: assert property (
		REG.wr && REG.addr == 8'h56 && REG.wdata[7] ##2 REG.rd && REG.addr == 8'h56
		|=> !REG_RDATA[7]) else $error("reload bit stuck");
	chk_active_smp: assert property (
		$past(RESET_N) && $changed(SENSOR_ACTIVE) |-> smp_q) else $error("active without sample");
	chk_base_smp: assert property (
		$past(RESET_N) && $changed(BASELINE0) |-> smp_q) else $error("baseline without sample");
endmodule
bind touch_tuning_regs touch_tuning_chk i_chk (
	.CLK(CLK), .RESET_N(RESET_N), .REG(REG), .SAMPLE(SAMPLE), .REG_RDATA(REG_RDATA),
	.SENSOR_ACTIVE(SENSOR_ACTIVE), .BASELINE0(BASELINE0), .SENSE_CURRENT0(SENSE_CURRENT0),
	.SENSE_CURRENT1(SENSE_CURRENT1), .BUS_ADDR(BUS_ADDR), .ADDRESS_LOCK_STATE(ADDRESS_LOCK_STATE)
);

// ### verification/touch_tuning_regs_tb.sv
// self-checking bench for the tuning register bank
`timescale 1ns/1ps
module touch_tuning_regs_tb;
	logic                       clk = 1'b0;
	logic                       reset_n = 1'b0;
	touch_tuning_pkg::reg_req_t req;
	touch_tuning_pkg::sample_t  smp;
	logic                       setup_mode;
	logic                       bus_active;
	logic [7:0]                 margin;
	logic [7:0]                 rdata;
	logic                       scan_ch;
	logic [1:0]                 active;
	logic [15:0]                base0;
	logic [15:0]                base1;
	logic [7:0]                 cur0;
	logic [7:0]                 cur1;
	logic [6:0]                 bus_addr;
	logic                       locked;
	logic [31:0]                seed = 32'h00002E5D;
	int                         fails = 0;
	int                         n_compared = 0;
	logic [7:0]                 v;
	logic [7:0]                 rv;
	logic [15:0]                b;
	logic [7:0] offs [13] = '{8'h53, 8'h54, 8'h55, 8'h56, 8'h5C, 8'h5D, 8'h66, 8'h67, 8'h70,
		8'h71, 8'h79, 8'h7C, 8'h60};
	logic [7:0] rsts [13] = '{8'h0A, 8'h0A, 8'h0A, 8'h20, 8'h00, 8'h01, 8'h64, 8'h64, 8'h0A,
		8'h0A, 8'h00, {1'b0, touch_tuning_pkg::RST_BUS_ADDR}, 8'h00};
	logic [7:0] rwo [5] = '{8'h53, 8'h54, 8'h55, 8'h66, 8'h67};
	// 40 MHz clock
	always #12.5 clk = ~clk;
	touch_host_model i_host (.clk(clk), .req(req), .rdata(rdata));
	touch_tuning_regs i_dut (.CLK(clk), .RESET_N(reset_n), .REG(req), .SETUP_MODE(setup_mode),
		.BUS_ACTIVE(bus_active), .THRESHOLD_MARGIN(margin), .SAMPLE(smp), .REG_RDATA(rdata),
		.SCAN_CH(scan_ch), .SENSOR_ACTIVE(active), .BASELINE0(base0), .BASELINE1(base1),
		.SENSE_CURRENT0(cur0), .SENSE_CURRENT1(cur1), .BUS_ADDR(bus_addr),
		.ADDRESS_LOCK_STATE(locked));
	// ==========
	// helpers
	function logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task check(input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			fails++;
			$display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
		end
	endtask
	task rdc(input logic [7:0] a, input logic [7:0] exp);
		i_host.rd(a, rv);
		check(rv, exp);
	endtask
	task sense(input logic [15:0] c);
		smp.count = c;
		smp.valid = 1'b1;
		@(posedge clk);
		#2;
		smp.valid = 1'b0;
		smp.count = ~c;
		@(posedge clk);
		#2;
	endtask
	task summarize();
		$display("compared %0d, mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// hang guard
	initial begin
		repeat (20000) @(posedge clk);
		fails++;
		summarize();
	end
	// ==========
	// main sequence
	initial begin
		smp = '0;
		setup_mode = 1'b0;
		bus_active = 1'b0;
		margin = 8'h0A;
		repeat (10) @(posedge clk);
		#2;
		reset_n = 1'b1;
		i_host.prepare();
		for (int i = 0; i < 13; i++) rdc(offs[i], rsts[i]);
		for (int i = 0; i < 5; i++) begin
			v = 8'h03 + 8'(xs() % 253);
			i_host.wr(rwo[i], v);
			rdc(rwo[i], v);
		end
		// current settings kept above four
		v = 8'h05 + 8'(xs() % 251);
		i_host.wr(8'h70, v);
		check(cur0, v);
		i_host.wr(8'h71, 8'h00);
		check(cur1, 8'h0A);
		// default scan alternates, first samples load baselines
		check(scan_ch, 0);
		sense(16'd1000);
		check(scan_ch, 1);
		sense(16'd2000);
		check(base1, 2000);
		check(scan_ch, 0);
		i_host.wr(8'h5C, 8'h01);
		rdc(8'h5C, 8'h00);
		setup_mode = 1'b1;
		i_host.wr(8'h5D, 8'h00);
		setup_mode = 1'b0;
		rdc(8'h5D, 8'h00);
		i_host.wr(8'h66, 8'h64);
		i_host.wr(8'h53, 8'h03);
		i_host.wr(8'h54, 8'h0A);
		i_host.wr(8'h55, 8'h03);
		// debounce restart, activation and release
		repeat (2) sense(base0 + 16'd200);
		sense(base0);
		repeat (2) sense(base0 + 16'd200);
		check(active[0], 0);
		sense(base0 + 16'd200);
		check(active[0], 1);
		sense(base0 + 16'd50);
		check(active[0], 0);
		i_host.wr(8'h53, 8'h01);
		sense(base0 + 16'd200);
		check(active[0], 1);
		sense(base0);
		check(active[0], 0);
		// low samples hold then reload the baseline
		b = base0;
		repeat (2) sense(b - 16'd50);
		check(base0, b);
		sense(b);
		repeat (2) sense(b - 16'd50);
		check(base0, b);
		sense(b - 16'd50);
		check(base0, b - 16'd50);
		// forced reload and busy drop
		i_host.wr(8'h56, 8'hA0);
		rdc(8'h56, 8'h20);
		sense(16'd3000);
		check(base0, 3000);
		bus_active = 1'b1;
		sense(16'd2995);
		bus_active = 1'b0;
		check(base0, 3000);
		i_host.wr(8'h56, 8'h00);
		bus_active = 1'b1;
		sense(16'd2995);
		bus_active = 1'b0;
		check(base0, 2995);
		for (int k = 0; k < 4; k++) begin
			i_host.wr(8'h56, 8'h10 | 8'(k));
			rdc(8'h56, 8'h10 | 8'(k));
		end
		v = 8'(xs());
		i_host.wr(8'h56, v & 8'h7F);
		rdc(8'h56, v & 8'h33);
		// two-sample averaging halves the first step seen by the threshold
		i_host.wr(8'h56, 8'h10);
		sense(base0 + 16'd200);
		check(active[0], 0);
		sense(base0 + 16'd200);
		check(active[0], 1);
		// address lock
		v = {2'b01, 6'(xs() % 64)};
		i_host.wr(8'h7C, v);
		check(bus_addr, touch_tuning_pkg::RST_BUS_ADDR);
		i_host.seq3(8'h96, 8'h5A, 8'hC3);
		check(locked, 1);
		check(bus_addr, v);
		i_host.wr(8'h7C, 8'h11);
		rdc(8'h7C, v);
		i_host.seq3(8'h3C, 8'h00, 8'h69);
		check(locked, 1);
		i_host.seq3(8'h3C, 8'hA5, 8'h69);
		rdc(8'h79, 8'h00);
		// lock again so the mid-run reset has something to undo
		i_host.seq3(8'h96, 8'h5A, 8'hC3);
		check(locked, 1);
		// second reset mid-run
		reset_n = 1'b0;
		@(posedge clk);
		#2;
		reset_n = 1'b1;
		rdc(8'h53, 8'h0A);
		check(locked, 0);
		check(bus_addr, touch_tuning_pkg::RST_BUS_ADDR);
		summarize();
	end
endmodule
